// *** acp_map.vh ***
// acp_map.vh: offsets, field positions, codes, limits and byte values for the command parser
// assumes inclusion by the parser and its bench; definitions only
`ifndef ACP_MAP_VH
`define ACP_MAP_VH

// register byte offsets on the axi4-lite slave
`define ACP_REG_JOB 8'h00
`define ACP_REG_STATUS 8'h04
`define ACP_REG_CAPSEL 8'h08
`define ACP_REG_SHUTTER 8'h0C
`define ACP_REG_AMPLIF 8'h10
`define ACP_REG_LENS 8'h14

// job register fields
`define ACP_JOB_LOADED_BIT 0
`define ACP_JOB_COUNT_LSB 4
`define ACP_JOB_RESET 32'h0000_0000

// status register fields
`define ACP_ST_MODE_LSB 0
`define ACP_ST_BUSY_BIT 4
`define ACP_ST_CODE_LSB 8

// modes
`define ACP_MODE_OFFLINE 2'h0
`define ACP_MODE_RUN 2'h1
`define ACP_MODE_SETUP 2'h2
`define ACP_MODE_RESET 2'h0

// completion codes
`define ACP_CODE_OK 7'h00
`define ACP_CODE_NOJOB 7'h01
`define ACP_CODE_BADIDX 7'h02
`define ACP_CODE_RANGE 7'h03
`define ACP_CODE_REFUSED 7'h63
`define ACP_CODE_FORMAT 7'h65

// capture table and value limits
`define ACP_CAPTURES 8
`define ACP_SHUTTER_MAX 16'h2710
`define ACP_AMPLIF_MAX 16'h0064
`define ACP_LENS_MAX 16'h03E8
`define ACP_VALUE_RESET 16'h0000

// frame bytes
`define ACP_CH_BANG 8'h21
`define ACP_CH_COMMA 8'h2C
`define ACP_CH_EQUAL 8'h3D
`define ACP_CH_CR 8'h0D
`define ACP_CH_LF 8'h0A
`define ACP_CH_ZERO 8'h30
`define ACP_CH_NINE 8'h39
`define ACP_NAME_MAX 4'hB

// command names, right aligned in an 88-bit buffer
`define ACP_NM_TRIGGER 88'h0000_0000_5452_4947_4745_52
`define ACP_NM_RUN 88'h0000_0000_0000_0000_5255_4E
`define ACP_NM_SETUP 88'h0000_0000_0000_5345_5455_50
`define ACP_NM_OFFLINE 88'h0000_0000_4F46_464C_494E_45
`define ACP_NM_SHUTTER 88'h5345_5445_5850_4F53_5552_45
`define ACP_NM_AMPLIF 88'h0000_0000_5345_5447_4149_4E
`define ACP_NM_LENS 88'h0000_5345_5446_4F43_5553

`endif

// *** acp_command_parser.v ***
// acp_command_parser.v: ascii command interpreter of a code reader, with axi4-lite registers
// assumes one 125 MHz clock; rx/tx byte streams come from logic on the same clock
// Function
// - frame starts with '!' and name, ends in CR; parse only at CR
// - arguments are separated from the name and each other by commas
// - answer '!', name, '=', decimal code, CR, LF; zero means success
// - trigger command starts a read cycle only in run or setup mode, answers 0
// - run command selects run mode and run view, answers 0
// - run mode permits job change, refuses job parameter changes
// - setup command selects setup mode and setup view, answers 0
// - setup mode refuses job change, accepts parameter changes
// - offline command selects offline mode and device view; triggers ignored
// - offline mode permits job change, refuses parameter changes
// - shutter command writes value into the 1-based capture of the loaded job
// - setting commands answer 1 with no job, before checking the index
// - setting commands answer 2 when the capture index does not exist
// - setting commands answer 101 when fewer than two arguments arrive
// - shutter command answers 3 and keeps the value when out of range
// - amplification command writes gain; 101 is out of range, answers 3
// - lens command writes focus; answers 3 when out of range
// - commands arrive on the same channels that carry result output
//
// Chosen here: the address map and the AXI4-Lite slave port.
`include "acp_map.vh"
`timescale 1ns/100ps
`default_nettype none

module acp_command_parser (
  input wire sys_clk_in,
  input wire reset_n_in,
  input wire [7:0] rx_data_in,
  input wire [1:0] rx_chan_in,
  input wire rx_valid_in,
  output reg rx_ready_out,
  output reg [7:0] tx_data_out,
  output reg [1:0] tx_chan_out,
  output reg tx_valid_out,
  input wire tx_ready_in,
  output reg [1:0] mode_out,
  output reg [1:0] view_out,
  output reg job_change_allowed_out,
  output reg read_trigger_out,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_NAME = 3'd1;
  localparam [2:0] ST_ARG = 3'd2;
  localparam [2:0] ST_EXEC = 3'd3;
  localparam [2:0] ST_RESP = 3'd4;

  reg [2:0] state;
  reg [87:0] name_buf;
  reg [3:0] name_len;
  reg [1:0] arg_cnt;
  reg [15:0] acc;
  reg [15:0] arg1;
  reg [15:0] arg2;
  reg [6:0] code;
  reg [4:0] pos;
  reg trig_pending;
  reg [1:0] mode;
  reg job_loaded;
  reg [3:0] cap_count;
  reg [2:0] cap_sel;
  reg wr_go;
  reg [1:0] wr_kind;
  reg [2:0] wr_idx;
  reg [15:0] wr_val;
  reg [15:0] shutter_mem [0:`ACP_CAPTURES-1];
  reg [15:0] amplif_mem [0:`ACP_CAPTURES-1];
  reg [15:0] lens_mem [0:`ACP_CAPTURES-1];

  wire rx_take = rx_valid_in & rx_ready_out;
  wire is_digit = (rx_data_in >= `ACP_CH_ZERO) && (rx_data_in <= `ACP_CH_NINE);
  wire [15:0] digit = {12'h000, rx_data_in[3:0]};
  wire [19:0] acc_x10 = {4'h0, acc} * 20'h0000A + {4'h0, digit};
  wire [15:0] acc_next = (acc_x10 > 20'h0FFFF) ? 16'hFFFF : acc_x10[15:0];

  // decode of the collected name
  wire is_trig = (name_buf == `ACP_NM_TRIGGER) && (name_len == 4'h7);
  wire is_run = (name_buf == `ACP_NM_RUN) && (name_len == 4'h3);
  wire is_setup = (name_buf == `ACP_NM_SETUP) && (name_len == 4'h5);
  wire is_off = (name_buf == `ACP_NM_OFFLINE) && (name_len == 4'h7);
  wire is_shut = (name_buf == `ACP_NM_SHUTTER) && (name_len == 4'hB);
  wire is_amp = (name_buf == `ACP_NM_AMPLIF) && (name_len == 4'h7);
  wire is_lens = (name_buf == `ACP_NM_LENS) && (name_len == 4'h8);
  wire is_param = is_shut | is_amp | is_lens;
  wire [15:0] val_max = is_shut ? `ACP_SHUTTER_MAX : (is_amp ? `ACP_AMPLIF_MAX : `ACP_LENS_MAX);

  // decimal digits of the completion code
  wire [6:0] dig_h = code / 7'd100;
  wire [6:0] dig_t = (code / 7'd10) % 7'd10;
  wire [6:0] dig_o = code % 7'd10;
  wire [1:0] n_dig = (code >= 7'd100) ? 2'd3 : ((code >= 7'd10) ? 2'd2 : 2'd1);
  wire [4:0] eq_pos = {1'b0, name_len} + 5'd1;
  wire [4:0] last_pos = eq_pos + {3'b000, n_dig} + 5'd3;

  reg [7:0] resp_byte;
  reg [4:0] dig_idx;
  always @* begin
    dig_idx = pos - eq_pos - 5'd1;
    if (pos == 5'd0) begin
      resp_byte = `ACP_CH_BANG;
    end else if (pos < eq_pos) begin
      resp_byte = name_buf[8 * (name_len - pos[3:0]) +: 8];
    end else if (pos == eq_pos) begin
      resp_byte = `ACP_CH_EQUAL;
    end else if (dig_idx < {3'b000, n_dig}) begin
      if (dig_idx == ({3'b000, n_dig} - 5'd1))
        resp_byte = `ACP_CH_ZERO | {1'b0, dig_o};
      else if ((dig_idx == 5'd0) && (n_dig == 2'd3))
        resp_byte = `ACP_CH_ZERO | {1'b0, dig_h};
      else
        resp_byte = `ACP_CH_ZERO | {1'b0, dig_t};
    end else if (pos == last_pos - 5'd2) begin
      resp_byte = `ACP_CH_CR;
    end else begin
      resp_byte = `ACP_CH_LF;
    end
  end

  // frame parser, executor and responder
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= ST_IDLE;
      name_buf <= 88'h0;
      name_len <= 4'h0;
      arg_cnt <= 2'd0;
      acc <= 16'h0000;
      arg1 <= 16'h0000;
      arg2 <= 16'h0000;
      code <= `ACP_CODE_OK;
      pos <= 5'd0;
      trig_pending <= 1'b0;
      mode <= `ACP_MODE_RESET;
      rx_ready_out <= 1'b0;
      tx_data_out <= 8'h00;
      tx_chan_out <= 2'd0;
      tx_valid_out <= 1'b0;
      read_trigger_out <= 1'b0;
      wr_go <= 1'b0;
      wr_kind <= 2'd0;
      wr_idx <= 3'd0;
      wr_val <= 16'h0000;
    end else begin
      read_trigger_out <= 1'b0;
      wr_go <= 1'b0;
      case (state)
        ST_IDLE: begin
          rx_ready_out <= 1'b1;
          if (rx_take && (rx_data_in == `ACP_CH_BANG)) begin
            state <= ST_NAME;
            tx_chan_out <= rx_chan_in;
            name_buf <= 88'h0;
            name_len <= 4'h0;
            arg_cnt <= 2'd0;
            acc <= 16'h0000;
          end
        end
        ST_NAME, ST_ARG: begin
          if (rx_take) begin
            if (rx_data_in == `ACP_CH_BANG) begin
              state <= ST_NAME;
              tx_chan_out <= rx_chan_in;
              name_buf <= 88'h0;
              name_len <= 4'h0;
              arg_cnt <= 2'd0;
              acc <= 16'h0000;
            end else if ((rx_data_in == `ACP_CH_COMMA) || (rx_data_in == `ACP_CH_CR)) begin
              if (state == ST_ARG) begin
                if (arg_cnt == 2'd1)
                  arg1 <= acc;
                if (arg_cnt == 2'd2)
                  arg2 <= acc;
              end
              acc <= 16'h0000;
              if (rx_data_in == `ACP_CH_CR) begin
                state <= ST_EXEC;
                rx_ready_out <= 1'b0;
              end else begin
                state <= ST_ARG;
                if (arg_cnt != 2'd3)
                  arg_cnt <= arg_cnt + 2'd1;
              end
            end else if (state == ST_NAME) begin
              if (name_len != `ACP_NAME_MAX) begin
                name_buf <= {name_buf[79:0], rx_data_in};
                name_len <= name_len + 4'h1;
              end
            end else if (is_digit) begin
              acc <= acc_next;
            end
          end
        end
        ST_EXEC: begin
          state <= ST_RESP;
          pos <= 5'd0;
          code <= `ACP_CODE_OK;
          if (is_trig) begin
            trig_pending <= (mode != `ACP_MODE_OFFLINE);
          end else if (is_run) begin
            mode <= `ACP_MODE_RUN;
          end else if (is_setup) begin
            mode <= `ACP_MODE_SETUP;
          end else if (is_off) begin
            mode <= `ACP_MODE_OFFLINE;
          end else if (is_param) begin
            if (arg_cnt < 2'd2)
              code <= `ACP_CODE_FORMAT;
            else if (mode != `ACP_MODE_SETUP)
              code <= `ACP_CODE_REFUSED;
            else if (!job_loaded)
              code <= `ACP_CODE_NOJOB;
            else if ((arg1 == 16'h0000) || (arg1 > {12'h000, cap_count}))
              code <= `ACP_CODE_BADIDX;
            else if (arg2 > val_max)
              code <= `ACP_CODE_RANGE;
            else begin
              wr_go <= 1'b1;
              wr_kind <= is_shut ? 2'd0 : (is_amp ? 2'd1 : 2'd2);
              wr_idx <= arg1[2:0] - 3'd1;
              wr_val <= arg2;
            end
          end else begin
            code <= `ACP_CODE_REFUSED;
          end
        end
        ST_RESP: begin
          if (!tx_valid_out || tx_ready_in) begin
            if (pos == last_pos) begin
              tx_valid_out <= 1'b0;
              state <= ST_IDLE;
              rx_ready_out <= 1'b1;
              read_trigger_out <= trig_pending;
              trig_pending <= 1'b0;
            end else begin
              tx_valid_out <= 1'b1;
              tx_data_out <= resp_byte;
              pos <= pos + 5'd1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // per-capture settings of the loaded job
  genvar gi;
  generate
    for (gi = 0; gi < `ACP_CAPTURES; gi = gi + 1) begin : g_cap
      always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          shutter_mem[gi] <= `ACP_VALUE_RESET;
          amplif_mem[gi] <= `ACP_VALUE_RESET;
          lens_mem[gi] <= `ACP_VALUE_RESET;
        end else if (wr_go && (wr_idx == gi)) begin
          if (wr_kind == 2'd0)
            shutter_mem[gi] <= wr_val;
          if (wr_kind == 2'd1)
            amplif_mem[gi] <= wr_val;
          if (wr_kind == 2'd2)
            lens_mem[gi] <= wr_val;
        end
      end
    end
  endgenerate

  // mode-derived outputs
  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mode_out <= `ACP_MODE_RESET;
      view_out <= `ACP_MODE_RESET;
      job_change_allowed_out <= 1'b0;
    end else begin
      mode_out <= mode;
      view_out <= mode;
      job_change_allowed_out <= (mode != `ACP_MODE_SETUP);
    end
  end

  // axi4-lite slave
  reg aw_got;
  reg w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire do_write = aw_got && w_got && !s_axi_bvalid;
  wire wr_hit = (aw_addr == `ACP_REG_JOB) || (aw_addr == `ACP_REG_CAPSEL);

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      job_loaded <= 1'b0;
      cap_count <= 4'h0;
      cap_sel <= 3'd0;
    end else begin
      s_axi_awready <= !aw_got && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_got && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
        if ((aw_addr == `ACP_REG_JOB) && w_strb[0]) begin
          job_loaded <= w_data[`ACP_JOB_LOADED_BIT];
          cap_count <= (w_data[`ACP_JOB_COUNT_LSB +: 4] > `ACP_CAPTURES) ?
                       4'd`ACP_CAPTURES : w_data[`ACP_JOB_COUNT_LSB +: 4];
        end
        if ((aw_addr == `ACP_REG_CAPSEL) && w_strb[0])
          cap_sel <= w_data[2:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `ACP_REG_JOB: s_axi_rdata <= {24'h0, cap_count, 3'b000, job_loaded};
          `ACP_REG_STATUS: s_axi_rdata <= {17'h0, code, 3'b000,
                                           (state != ST_IDLE), 2'b00, mode};
          `ACP_REG_CAPSEL: s_axi_rdata <= {29'h0, cap_sel};
          `ACP_REG_SHUTTER: s_axi_rdata <= {16'h0, shutter_mem[cap_sel]};
          `ACP_REG_AMPLIF: s_axi_rdata <= {16'h0, amplif_mem[cap_sel]};
          `ACP_REG_LENS: s_axi_rdata <= {16'h0, lens_mem[cap_sel]};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // acp_command_parser

`default_nettype wire

// *** acp_chk.sv ***
// acp_chk.sv: port assertions for the command parser
// assumes bind onto acp_command_parser, one clock, async low reset
`timescale 1ns/100ps
`default_nettype none
module acp_chk (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic [7:0] rx_data_in,
  input wire logic rx_valid_in,
  input wire logic rx_ready_out,
  input wire logic [7:0] tx_data_out,
  input wire logic [1:0] tx_chan_out,
  input wire logic tx_valid_out,
  input wire logic tx_ready_in,
  input wire logic [1:0] mode_out,
  input wire logic [1:0] view_out,
  input wire logic job_change_allowed_out,
  input wire logic read_trigger_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  wire cr_take = rx_valid_in && rx_ready_out && rx_data_in == 8'h0D;
  wire lf_done = tx_valid_out && tx_ready_in && tx_data_out == 8'h0A;

  a_cr_stops_rx: assert property (cr_take |=> !rx_ready_out)
    else $error("byte intake open after frame end");
  a_reply_start: assert property (cr_take |-> ##3 (tx_valid_out && tx_data_out == 8'h21))
    else $error("reply does not open three cycles after frame end");
  a_tx_hold: assert property (tx_valid_out && !tx_ready_in |=>
    tx_valid_out && $stable(tx_data_out) && $stable(tx_chan_out))
    else $error("reply byte changed before taken");
  a_busy_no_rx: assert property (tx_valid_out |-> !rx_ready_out)
    else $error("intake open while replying");
  a_lf_release: assert property (lf_done |=> !tx_valid_out && rx_ready_out)
    else $error("intake not reopened after reply end");
  a_trig_after_lf: assert property (read_trigger_out |-> $past(lf_done))
    else $error("trigger pulse not right after reply");
  a_trig_single: assert property (read_trigger_out |=> !read_trigger_out)
    else $error("trigger pulse longer than one cycle");
  a_trig_mode: assert property (read_trigger_out |-> mode_out != 2'h0)
    else $error("trigger pulse while offline");
  a_view_follow: assert property (view_out == mode_out)
    else $error("view differs from mode");
  a_job_perm: assert property ($past(reset_n_in) |->
    job_change_allowed_out == (mode_out != 2'h2))
    else $error("job change permission wrong for mode");
endmodule // acp_chk

bind acp_command_parser acp_chk i_chk (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
  .rx_data_in(rx_data_in), .rx_valid_in(rx_valid_in), .rx_ready_out(rx_ready_out),
  .tx_data_out(tx_data_out), .tx_chan_out(tx_chan_out), .tx_valid_out(tx_valid_out),
  .tx_ready_in(tx_ready_in), .mode_out(mode_out), .view_out(view_out),
  .job_change_allowed_out(job_change_allowed_out), .read_trigger_out(read_trigger_out));
`default_nettype wire

// *** acp_host_model.sv ***
// acp_host_model.sv: host that sends command frames and takes replies
// assumes the parser's clock; frames are handed in by the bench
`timescale 1ns/100ps
`default_nettype none
module acp_host_model (
  input wire logic clk_in,
  input wire logic stall_in,
  input wire logic rx_ready_in,
  output var logic [7:0] rx_data_out,
  output var logic [1:0] rx_chan_out,
  output var logic rx_valid_out,
  input wire logic [7:0] tx_data_in,
  input wire logic [1:0] tx_chan_in,
  input wire logic tx_valid_in,
  output var logic tx_ready_out
);
  logic [7:0] reply [$];
  logic [1:0] reply_chan;
  initial begin
    rx_data_out = 8'h00;
    rx_chan_out = 2'h0;
    rx_valid_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  always @(posedge clk_in) begin
    tx_ready_out <= !stall_in;
    if (tx_valid_in && tx_ready_out) begin
      reply.push_back(tx_data_in);
      reply_chan <= tx_chan_in;
    end
  end
  // whole frame, each byte held until taken
  task automatic send(input logic [7:0] f [$], input logic [1:0] ch);
    foreach (f[i]) begin
      rx_data_out <= f[i];
      rx_chan_out <= ch;
      rx_valid_out <= 1'b1;
      do @(posedge clk_in); while (!rx_ready_in);
    end
    rx_valid_out <= 1'b0;
    rx_data_out <= ~f[f.size() - 1];
  endtask
endmodule // acp_host_model
`default_nettype wire

// *** acp_command_parser_tb.sv ***
// acp_command_parser_tb.sv: self-checking bench for the command parser
// assumes acp_host_model and acp_chk compiled first
`include "acp_map.vh"
`timescale 1ns/100ps
`default_nettype none
module acp_command_parser_tb;
  logic clk, rst_n, slow, stall, txr, txv, rxr, rxv, jca, trg;
  logic [7:0] rxd, txd, awaddr, araddr;
  logic [3:0] wstrb;
  logic [1:0] rxc, txc, mode, view, bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [87:0] mn [3], ps [3];
  int lim [3], par [3][8], m, loaded, cnt, trig_exp, trig_seen, fail_count, total_checks;
  integer seed = 38;

  acp_command_parser i_dut (.sys_clk_in(clk), .reset_n_in(rst_n), .rx_data_in(rxd),
    .rx_chan_in(rxc), .rx_valid_in(rxv), .rx_ready_out(rxr), .tx_data_out(txd),
    .tx_chan_out(txc), .tx_valid_out(txv), .tx_ready_in(txr), .mode_out(mode),
    .view_out(view), .job_change_allowed_out(jca), .read_trigger_out(trg),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  acp_host_model i_host (.clk_in(clk), .stall_in(stall), .rx_ready_in(rxr),
    .rx_data_out(rxd), .rx_chan_out(rxc), .rx_valid_out(rxv), .tx_data_in(txd),
    .tx_chan_in(txc), .tx_valid_in(txv), .tx_ready_out(txr));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    stall <= slow && $random(seed) % 2 != 0;
    if (trg === 1'b1) trig_seen <= trig_seen + 1;
  end

  task automatic chk(input logic [31:0] seen, exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     output logic [1:0] r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    fork
      begin do @(posedge clk); while (!awready); awvalid <= 1'b0; end
      begin do @(posedge clk); while (!wready); wvalid <= 1'b0; end
    join
    while (!bvalid) @(posedge clk);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk);
  endtask
  function automatic void dec(ref logic [7:0] q [$], input int v);
    if (v > 9) dec(q, v / 10);
    q.push_back(8'(8'h30 + v % 10));
  endfunction

  // send one frame, predict the reply and the state it leaves
  task automatic cmd(input logic [87:0] nm, input int n, a, b);
    logic [7:0] f [$], e [$];
    logic [31:0] st;
    logic [1:0] ch, r;
    int k, code;
    ch = 2'($random(seed));
    f = {8'h21};
    for (int i = 10; i >= 0; i--) if (nm[i*8+:8] != 8'h00) f.push_back(nm[i*8+:8]);
    e = f;
    if (n > 0) begin f.push_back(8'h2C); dec(f, a); end
    if (n > 1) begin f.push_back(8'h2C); dec(f, b); end
    f.push_back(8'h0D);
    k = nm == ps[0] ? 0 : nm == ps[1] ? 1 : nm == ps[2] ? 2 : 3;
    code = 0;
    if (nm == mn[0]) m = 0;
    else if (nm == mn[1]) m = 1;
    else if (nm == mn[2]) m = 2;
    else if (k == 3) trig_exp += m != 0;
    else if (n < 2) code = 101;
    else if (m != 2) code = 99;
    else if (!loaded) code = 1;
    else if (a < 1 || a > cnt) code = 2;
    else if (b > lim[k]) code = 3;
    else par[k][a-1] = b;
    e.push_back(8'h3D);
    dec(e, code);
    e.push_back(8'h0D);
    e.push_back(8'h0A);
    i_host.send(f, ch);
    while (i_host.reply.size() < e.size()) @(posedge clk);
    repeat (2) @(posedge clk);
    chk(i_host.reply.size(), e.size(), "reply length");
    foreach (e[i]) chk(i_host.reply[i], e[i], "reply byte");
    chk(i_host.reply_chan, ch, "reply channel");
    i_host.reply = {};
    chk(mode, m, "mode");
    chk(view, m, "view");
    chk(jca, m != 2, "job change");
    chk(trig_seen, trig_exp, "triggers");
    axr(`ACP_REG_STATUS, st, r);
    chk(st[14:8], code, "status code");
    if (k < 3 && a >= 1 && a <= cnt) begin
      axw(`ACP_REG_CAPSEL, a - 1, 4'hF, r);
      axr(`ACP_REG_SHUTTER + 8'(4 * k), st, r);
      chk(st, par[k][a-1], "capture value");
    end
  endtask

  initial begin
    fork
      begin #400000; fail_count++; complete_run; end
    join_none
  end
  initial begin
    logic [31:0] st;
    logic [1:0] r;
    {rst_n, slow, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    par = '{default: 0};
    mn = '{`ACP_NM_OFFLINE, `ACP_NM_RUN, `ACP_NM_SETUP};
    ps = '{`ACP_NM_SHUTTER, `ACP_NM_AMPLIF, `ACP_NM_LENS};
    lim = '{int'(`ACP_SHUTTER_MAX), int'(`ACP_AMPLIF_MAX), int'(`ACP_LENS_MAX)};
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    axr(`ACP_REG_JOB, st, r);
    chk(st, `ACP_JOB_RESET, "job reset");
    axr(8'h18, st, r);
    chk(r, 2'b10, "unmapped read response");
    chk(st, 32'h0, "unmapped read data");
    axw(8'h1C, 32'h1, 4'hF, r);
    chk(r, 2'b10, "unmapped write");
    $display("register test done");
    for (int i = 0; i < 3; i++) begin
      cmd(mn[i], 0, 0, 0);
      cmd(`ACP_NM_TRIGGER, 0, 0, 0);
      cmd(ps[i], 2, 9, 5);
    end
    $display("mode test done");
    axw(`ACP_REG_JOB, 32'h31, 4'hF, r);
    loaded = 1;
    cnt = 3;
    // byte lane 0 off: the job word must stay as it is
    axw(`ACP_REG_JOB, 32'h0, 4'($random(seed)) & 4'hE, r);
    chk(r, 2'b00, "masked write response");
    axr(`ACP_REG_JOB, st, r);
    chk(st, 32'h31, "masked job write");
    for (int k = 0; k < 3; k++) begin
      slow <= k == 1;
      cmd(ps[k], k % 2, 1, 0);
      cmd(ps[k], 2, 0, 5);
      cmd(ps[k], 2, 4, 5);
      cmd(ps[k], 2, 3, lim[k]);
      cmd(ps[k], 2, 3, lim[k] + 1);
      repeat (3) cmd(ps[k], 2, 1 + $unsigned($random(seed)) % 3,
        $unsigned($random(seed)) % (lim[k] + 1));
      $display("parameter test %0d done", k);
    end
    for (int i = 1; i >= 0; i--) begin
      cmd(mn[i], 0, 0, 0);
      cmd(ps[1], 2, 1, 50);
      cmd(`ACP_NM_TRIGGER, 0, 0, 0);
    end
    $display("refusal test done");
    complete_run;
  end
endmodule // acp_command_parser_tb
`default_nettype wire
